//--- src/sw_reset_pkg.sv
// Register map, field layout and carrier types for the peripheral software reset block
package sw_reset_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CAP_MASK_A   = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_CAP_MASK_B   = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_RESET_CTRL_A = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_RESET_CTRL_B = 12'h044;
	localparam logic [ADDR_W-1:0] OFS_DROP_STATUS  = 12'h050;

	// Field positions, first reset register
	localparam int POS_BUS_UNIT_ZERO  = 24;
	localparam int POS_CONVERTER_ZERO = 16;
	localparam int POS_HIBERNATE      = 6;
	localparam int POS_WATCHDOG       = 3;

	// Field positions, second reset register
	localparam int POS_COMPARATOR_ZERO = 24;
	localparam int POS_GP_COUNTER_LO   = 16;
	localparam int POS_TWO_WIRE_ZERO   = 12;
	localparam int POS_SYNC_SERIAL_LO  = 4;
	localparam int POS_UART_LO         = 0;
	localparam int NUM_GP_COUNTER      = 4;
	localparam int NUM_SYNC_SERIAL     = 2;
	localparam int NUM_UART            = 3;

	// Implemented (non-reserved) bits
	localparam logic [DATA_W-1:0] FIELDS_A = 32'h0101_0048;
	localparam logic [DATA_W-1:0] FIELDS_B = 32'h010F_1037;

	// Units present on this build; software reads these as capability masks
	localparam logic [DATA_W-1:0] CAP_MASK_A_VAL = 32'h0101_0048;
	localparam logic [DATA_W-1:0] CAP_MASK_B_VAL = 32'h010F_1037;

	// Values after reset
	localparam logic [DATA_W-1:0] RESET_CTRL_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] READ_DATA_RST  = 32'h0000_0000;
	localparam logic [1:0]        DROP_FLAG_RST  = 2'h0;

	// Drop status bit positions
	localparam int POS_DROP_A = 0;
	localparam int POS_DROP_B = 1;
	localparam int NUM_DROP   = 2;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic                       bus_unit_zero_reset;
		logic                       converter_zero_reset;
		logic                       hibernate_block_reset;
		logic                       watchdog_reset;
		logic                       comparator_zero_reset;
		logic [NUM_GP_COUNTER-1:0]  gp_counter_reset;
		logic                       two_wire_0_reset;
		logic [NUM_SYNC_SERIAL-1:0] sync_serial_reset;
		logic [NUM_UART-1:0]        uart_reset;
	} unit_resets_type;

endpackage

//--- src/masked_ctrl_reg.sv
// Control register whose writes reach only the bits set in its write mask
`timescale 1ns/1ps
module masked_ctrl_reg
	import sw_reset_pkg::*;
#(
	parameter logic [DATA_W-1:0] WRITE_MASK = 32'h0000_0000
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              wr_en,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] value_r,
	output logic                   blocked
);

	logic [DATA_W-1:0] value_nxt;

	// Masked bits keep their stored value, so reserved and absent units stay zero
	always_comb begin
		value_nxt = (value_r & ~WRITE_MASK) | (wdata & WRITE_MASK);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			value_r <= RESET_CTRL_RST;
		end else if (wr_en) begin
			value_r <= value_nxt;
		end
	end

	// A write that tried to set a bit it may not touch
	assign blocked = wr_en && ((wdata & ~WRITE_MASK) != 32'h0000_0000);

endmodule

//--- src/sticky_flags.sv
// Sticky flags: hardware set, software write-one-to-clear, set beats clear
`timescale 1ns/1ps
module sticky_flags
	import sw_reset_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic [NUM_DROP-1:0] set,
	input  wire logic [NUM_DROP-1:0] clear,
	output logic      [NUM_DROP-1:0] flag_r
);

	genvar i;
	generate
		for (i = 0; i < NUM_DROP; i++) begin : g_flag
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					flag_r[i] <= DROP_FLAG_RST[i];
				end else if (set[i]) begin
					flag_r[i] <= 1'b1;
				end else if (clear[i]) begin
					flag_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

//--- src/peripheral_software_reset_control.sv
// Software reset control registers driving per-unit peripheral reset lines
//
// Overview of operation
// RULE_01: first register writes gated by first capability mask
// RULE_02: second register writes gated by second capability mask
// RULE_03: first register bit 24 resets bus unit zero
// RULE_04: first register bit 16 resets converter zero
// RULE_05: first register bit 6 resets hibernate block
// RULE_06: first register bit 3 resets watchdog
// RULE_07: second register bit 24 resets comparator zero
// RULE_08: second register bits 19:16 reset counters 3..0
// RULE_09: second register bit 12 resets two-wire unit
// RULE_10: second register bits 5:4 reset serial 1..0
// RULE_11: second register bits 2:0 reset UART 2..0
// RULE_12: reserved bits read-only zero; software preserves them
// RULE_13: both registers clear after system reset
// RULE_14: reset held while bit set, released on clear
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module peripheral_software_reset_control
	import sw_reset_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata,
	output unit_resets_type        unit_resets
);

	bus_req_type       req;
	logic [DATA_W-1:0] ctrl_a;
	logic [DATA_W-1:0] ctrl_b;
	logic              blocked_a;
	logic              blocked_b;
	logic              wr_ctrl_a;
	logic              wr_ctrl_b;
	logic              wr_drop;
	logic [NUM_DROP-1:0] drop_set;
	logic [NUM_DROP-1:0] drop_clear;
	logic [NUM_DROP-1:0] drop_flags;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	assign req.wr    = wr_stb;
	assign req.rd    = rd_stb;
	assign req.addr  = addr;
	assign req.wdata = wdata;

	assign wr_ctrl_a = req.wr && (req.addr == OFS_RESET_CTRL_A);
	assign wr_ctrl_b = req.wr && (req.addr == OFS_RESET_CTRL_B);
	assign wr_drop   = req.wr && (req.addr == OFS_DROP_STATUS);

	// Only documented fields of present units are writable
	masked_ctrl_reg #(
		.WRITE_MASK (CAP_MASK_A_VAL & FIELDS_A) // RULE_01
	) u_ctrl_a (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wr_en   (wr_ctrl_a),
		.wdata   (req.wdata),
		.value_r (ctrl_a), // RULE_13
		.blocked (blocked_a)
	);

	masked_ctrl_reg #(
		.WRITE_MASK (CAP_MASK_B_VAL & FIELDS_B) // RULE_02
	) u_ctrl_b (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wr_en   (wr_ctrl_b),
		.wdata   (req.wdata),
		.value_r (ctrl_b), // RULE_13
		.blocked (blocked_b)
	);

	// Records writes whose masked-off bits were dropped, so software can spot a bad RMW
	assign drop_set[POS_DROP_A]   = blocked_a;
	assign drop_set[POS_DROP_B]   = blocked_b;
	assign drop_clear             = wr_drop ? req.wdata[NUM_DROP-1:0] : 2'h0;

	sticky_flags u_drop (
		.ref_clk (ref_clk),
		.rst     (rst),
		.set     (drop_set),
		.clear   (drop_clear),
		.flag_r  (drop_flags)
	);

	// Reset lines follow the stored bits directly: held while set
	assign unit_resets.bus_unit_zero_reset   = ctrl_a[POS_BUS_UNIT_ZERO]; // RULE_03 RULE_14
	assign unit_resets.converter_zero_reset  = ctrl_a[POS_CONVERTER_ZERO]; // RULE_04
	assign unit_resets.hibernate_block_reset = ctrl_a[POS_HIBERNATE]; // RULE_05
	assign unit_resets.watchdog_reset        = ctrl_a[POS_WATCHDOG]; // RULE_06
	assign unit_resets.comparator_zero_reset = ctrl_b[POS_COMPARATOR_ZERO]; // RULE_07
	assign unit_resets.gp_counter_reset      =
		ctrl_b[POS_GP_COUNTER_LO +: NUM_GP_COUNTER]; // RULE_08
	assign unit_resets.two_wire_0_reset      = ctrl_b[POS_TWO_WIRE_ZERO]; // RULE_09
	assign unit_resets.sync_serial_reset     =
		ctrl_b[POS_SYNC_SERIAL_LO +: NUM_SYNC_SERIAL]; // RULE_10
	assign unit_resets.uart_reset            = ctrl_b[POS_UART_LO +: NUM_UART]; // RULE_11

	// Reserved bits never store anything, so they read as zero
	always_comb begin
		rdata_nxt = READ_DATA_RST;
		if (req.rd) begin
			case (req.addr)
				OFS_RESET_CTRL_A: rdata_nxt = ctrl_a & FIELDS_A; // RULE_12
				OFS_RESET_CTRL_B: rdata_nxt = ctrl_b & FIELDS_B; // RULE_12
				OFS_CAP_MASK_A:   rdata_nxt = CAP_MASK_A_VAL;
				OFS_CAP_MASK_B:   rdata_nxt = CAP_MASK_B_VAL;
				OFS_DROP_STATUS:  rdata_nxt = {{(DATA_W-NUM_DROP){1'b0}}, drop_flags};
				default:          rdata_nxt = READ_DATA_RST;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= READ_DATA_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

endmodule

//--- testbench/sw_reset_props.sv
// Checker for the software reset control block
`timescale 1ns/1ps
module sw_reset_props
	import sw_reset_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W-1:0] rdata,
	input wire unit_resets_type   unit_resets
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [DATA_W-1:0] wd_r;
	wire               wa = wr_stb && addr == OFS_RESET_CTRL_A;
	wire               wb = wr_stb && addr == OFS_RESET_CTRL_B;
	always_ff @(posedge ref_clk) wd_r <= wdata;
	property p_cap_a; rd_stb && addr == OFS_CAP_MASK_A |=> rdata == CAP_MASK_A_VAL; endproperty
	a_cap_a: assert property (p_cap_a) else $error("capability A read wrong");
	property p_cap_b; rd_stb && addr == OFS_CAP_MASK_B |=> rdata == CAP_MASK_B_VAL; endproperty
	a_cap_b: assert property (p_cap_b) else $error("capability B read wrong");
	property p_can; wa |=> unit_resets.bus_unit_zero_reset == wd_r[24]; endproperty
	a_can: assert property (p_can) else $error("bus unit line wrong");
	property p_conv; wa |=> unit_resets.converter_zero_reset == wd_r[16]; endproperty
	a_conv: assert property (p_conv) else $error("converter line wrong");
	property p_hw;
		wa |=> {unit_resets.hibernate_block_reset, unit_resets.watchdog_reset} == {wd_r[6], wd_r[3]};
	endproperty
	a_hw: assert property (p_hw) else $error("hibernate or watchdog line wrong");
	property p_cmp;
		wb |=> {unit_resets.comparator_zero_reset, unit_resets.gp_counter_reset}
			== {wd_r[24], wd_r[19:16]};
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator or counter lines wrong");
	property p_ser;
		wb |=> {unit_resets.two_wire_0_reset, unit_resets.sync_serial_reset, unit_resets.uart_reset}
			== {wd_r[12], wd_r[5:4], wd_r[2:0]};
	endproperty
	a_ser: assert property (p_ser) else $error("serial lines wrong");
	property p_resv; rd_stb && addr == OFS_RESET_CTRL_A |=> (rdata & ~FIELDS_A) == 32'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bit read nonzero");
	property p_resv_b; rd_stb && addr == OFS_RESET_CTRL_B |=> (rdata & ~FIELDS_B) == 32'h0; endproperty
	a_resv_b: assert property (p_resv_b) else $error("reserved bit B read nonzero");
	property p_idle; !rd_stb |=> rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data without read strobe");
	property p_hold; !(wa || wb) |=> $stable(unit_resets); endproperty
	a_hold: assert property (p_hold) else $error("reset line moved without write");
endmodule
bind peripheral_software_reset_control sw_reset_props u_props(.ref_clk, .rst, .wr_stb, .rd_stb,
	.addr, .wdata, .rdata, .unit_resets);

//--- testbench/unit_farm.sv
// Behavioural peripheral units that count only while out of reset
`timescale 1ns/1ps
module unit_farm
	import sw_reset_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  unit_resets_type  unit_resets,
	output logic      [15:0] run_cnt_r
);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst || |unit_resets) run_cnt_r <= 16'h0;
		else run_cnt_r <= run_cnt_r + 16'h1;
	end
endmodule

//--- testbench/peripheral_software_reset_control_tb.sv
// Self-checking bench for the software reset control block
`timescale 1ns/1ps
module peripheral_software_reset_control_tb import sw_reset_pkg::*; ;
	logic              ref_clk = 0;
	logic              rst = 1;
	logic              wr_stb = 0;
	logic              rd_stb = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	unit_resets_type   unit_resets;
	logic [15:0]       run_cnt_r;
	int                fail_count = 0;
	int                compares = 0;
	int                cyc = 0;
	always #20 ref_clk = ~ref_clk;
	peripheral_software_reset_control DUT(.ref_clk, .rst, .wr_stb, .rd_stb, .addr, .wdata,
		.rdata, .unit_resets);
	unit_farm farm(.ref_clk, .rst, .unit_resets, .run_cnt_r);
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_u(unit_resets_type e);
		compares++;
		if (unit_resets !== e) begin
			fail_count++;
			$display("BAD unit_resets expected %h seen %h", e, unit_resets);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge ref_clk);
		wr_stb <= 1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_stb <= 0;
		#1;
	endtask
	task automatic rd(string n, logic [11:0] a, logic [31:0] e);
		@(posedge ref_clk);
		rd_stb <= 1;
		addr <= a;
		@(posedge ref_clk);
		rd_stb <= 0;
		#1;
		cmp(n, e, rdata);
	endtask
	function automatic unit_resets_type ex(logic [31:0] a, logic [31:0] b);
		return {a[24], a[16], a[6], a[3], b[24], b[19:16], b[12], b[5:4], b[2:0]};
	endfunction
	task automatic s_caps();
		cmp_u(ex(32'h0, 32'h0));
		rd("ctrl_a", OFS_RESET_CTRL_A, 32'h0);
		rd("ctrl_b", OFS_RESET_CTRL_B, 32'h0);
		wr(OFS_CAP_MASK_A, 32'h0);
		rd("cap_a", OFS_CAP_MASK_A, 32'h0101_0048);
		rd("cap_b", OFS_CAP_MASK_B, 32'h010F_1037);
		wr(12'h048, 32'hFFFF_FFFF);
		rd("unmapped", 12'h048, 32'h0);
	endtask
	// Every bit once, reserved ones too, so a stray mapping shows
	task automatic s_walk();
		logic [31:0] v;
		for (int i = 0; i < 32; i++) begin
			v = 32'h1 << i;
			wr(OFS_RESET_CTRL_A, v);
			cmp_u(ex(v & 32'h0101_0048, 32'h0));
			rd("ctrl_a", OFS_RESET_CTRL_A, v & 32'h0101_0048);
		end
		for (int i = 0; i < 32; i++) begin
			v = 32'h1 << i;
			wr(OFS_RESET_CTRL_B, v);
			cmp_u(ex(32'h0, v & 32'h010F_1037));
			rd("ctrl_b", OFS_RESET_CTRL_B, v & 32'h010F_1037);
		end
	endtask
	// Walk wrote reserved bits in both registers, so both drop flags stand
	task automatic s_drop();
		rd("drop", OFS_DROP_STATUS, 32'h3);
		wr(OFS_DROP_STATUS, 32'h1);
		rd("drop", OFS_DROP_STATUS, 32'h2);
		wr(OFS_DROP_STATUS, 32'h2);
		rd("drop", OFS_DROP_STATUS, 32'h0);
		wr(OFS_RESET_CTRL_A, 32'h0101_0048);
		rd("drop", OFS_DROP_STATUS, 32'h0);
		wr(OFS_RESET_CTRL_A, 32'h8000_0000);
		rd("drop", OFS_DROP_STATUS, 32'h1);
		cmp_u(ex(32'h0, 32'h0));
	endtask
	task automatic s_hold();
		wr(OFS_RESET_CTRL_B, 32'h1);
		repeat (3) @(posedge ref_clk);
		#1;
		cmp("run_cnt", 32'h0, {16'h0, run_cnt_r});
		wr(OFS_RESET_CTRL_B, 32'h0);
		repeat (4) @(posedge ref_clk);
		#1;
		cmp("run_cnt", 32'h4, {16'h0, run_cnt_r});
	endtask
	task automatic s_midrst();
		wr(OFS_RESET_CTRL_A, 32'hFFFF_FFFF);
		wr(OFS_RESET_CTRL_B, 32'hFFFF_FFFF);
		cmp_u(ex(32'h0101_0048, 32'h010F_1037));
		@(posedge ref_clk);
		rst <= 1;
		@(posedge ref_clk);
		rst <= 0;
		#1;
		cmp_u(ex(32'h0, 32'h0));
		rd("ctrl_a", OFS_RESET_CTRL_A, 32'h0);
		rd("ctrl_b", OFS_RESET_CTRL_B, 32'h0);
		rd("drop", OFS_DROP_STATUS, 32'h0);
	endtask
	task automatic close_out();
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 0;
		s_caps();
		s_walk();
		s_drop();
		s_hold();
		s_midrst();
		close_out();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end
endmodule
